// ### logic/serial_port_pkg.sv
// package: constants, register map and state types of the serial remote port
package serial_port_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_BAUD   = 12'h004;
  localparam logic [11:0] ADDR_TXDATA = 12'h008;
  localparam logic [11:0] ADDR_RXDATA = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // cfg field positions
  localparam int CFG_WORD8    = 0;
  localparam int CFG_STOP2    = 1;
  localparam int CFG_PAR_LSB  = 2;
  localparam int CFG_ECHO     = 5;
  localparam int CFG_TXPACE   = 6;
  localparam int CFG_RXPACE   = 7;
  localparam int CFG_RTS_LSB  = 8;
  localparam int CFG_DTR_LSB  = 10;
  localparam int CFG_BALANCED = 12;
  localparam logic [12:0] CFG_RESET = 13'h0_001;

  // parity modes
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD  = 3'h2;
  localparam logic [2:0] PAR_ZERO = 3'h3;
  localparam logic [2:0] PAR_ONE  = 3'h4;

  // handshake line modes
  localparam logic [1:0] HS_OFF  = 2'h0;
  localparam logic [1:0] HS_ON   = 2'h1;
  localparam logic [1:0] HS_ROOM = 2'h2;

  // baud divisor: clocks per bit minus one, default 9600 baud at 20 MHz
  localparam logic [15:0] BAUD_RESET = 16'h0_823;
  localparam logic [7:0] CHAR_XON  = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [3:0] ST_TX_PEND = 4'h0;

  typedef enum logic [2:0] {
    LN_IDLE  = 3'b000,
    LN_START = 3'b001,
    LN_DATA  = 3'b010,
    LN_PAR   = 3'b011,
    LN_STOP  = 3'b100
  } line_state_t;

  typedef struct packed {
    logic txd;
    logic rts;
    logic dtr;
  } link_out_t;

  typedef struct packed {
    logic rxd;
    logic cts;
    logic dsr;
  } link_in_t;

  typedef struct packed {
    logic [12:0] cfg;
    logic [15:0] baud;
    logic [7:0] tx_hold;
    logic tx_hold_v;
    logic [7:0] rx_hold;
    logic rx_hold_v;
    logic overrun;
    logic [7:0] echo_hold;
    logic echo_v;
    logic far_paused;
    logic xoff_sent;
    logic send_xoff;
    logic send_xon;
    line_state_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_stop2;
    logic tx_is_ctl;
    line_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic perr;
    logic ferr;
    logic [31:0] prdata;
    link_out_t lo;
  } port_state_t;
endpackage : serial_port_pkg

// ### logic/serial_remote_port.sv
// serial remote port: uart with parity, echo and software/hardware pacing
// Operation
// - seven or eight data bits per character
// - one or two stop bits
// - parity even, odd, zero, one, none
// - echo returns every received character except XOFF/XON taken while transmit pacing is on
// - transmitter obeys far XOFF/XON when enabled
// - receiver sends XOFF/XON when enabled
// - rts off low, on high
// - rts high while receive buffer has room
// - rts room mode: hold transmit while cts low
// - dtr off low, on high
// - dtr high while receive buffer has room
// - dtr room mode: hold transmit while dsr low
// - dtr/dsr mode unavailable on balanced line
// - port is terminal: drives rts/dtr, samples cts/dsr
`timescale 1ns/1ns
module serial_remote_port
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire link_in_t link_in,
  output link_out_t link_out
);

  port_state_t s_r;
  port_state_t s_nxt;

  logic wr_en;
  logic rd_en;
  logic word8;
  logic [2:0] par_mode;
  logic [1:0] rts_mode;
  logic [1:0] dtr_mode;
  logic room;
  logic hw_hold;
  logic [15:0] half_baud;
  logic rx_done;
  logic [7:0] rx_char;
  logic mapped;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign word8 = s_r.cfg[CFG_WORD8];
  assign par_mode = s_r.cfg[CFG_PAR_LSB +: 3];
  assign rts_mode = s_r.cfg[CFG_RTS_LSB +: 2];
  // balanced line forces the dtr pair off
  assign dtr_mode = s_r.cfg[CFG_BALANCED] ? HS_OFF : s_r.cfg[CFG_DTR_LSB +: 2];
  // one-character receive buffer: room means the holding slot is empty
  assign room = ~s_r.rx_hold_v;
  assign hw_hold = ((rts_mode == HS_ROOM) & ~link_in.cts)
                 | ((dtr_mode == HS_ROOM) & ~link_in.dsr);
  assign half_baud = {1'b0, s_r.baud[15:1]};
  assign rx_char = word8 ? s_r.rx_sh : {1'b0, s_r.rx_sh[7:1]};
  assign mapped = (paddr == ADDR_CFG) | (paddr == ADDR_BAUD) | (paddr == ADDR_TXDATA)
                | (paddr == ADDR_RXDATA) | (paddr == ADDR_STATUS);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s_r.prdata;
  assign link_out = s_r.lo;

  always_comb begin
    s_nxt = s_r;
    rx_done = 1'b0;

    // ****************************************
    // apb register access
    // ****************************************
    if (wr_en) begin
      case (paddr)
        ADDR_CFG: s_nxt.cfg = pwdata[12:0];
        ADDR_BAUD: s_nxt.baud = pwdata[15:0];
        ADDR_TXDATA: begin
          if (!s_r.tx_hold_v) begin
            s_nxt.tx_hold = pwdata[7:0];
            s_nxt.tx_hold_v = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    s_nxt.prdata = 32'h0000_0000;
    // read data is loaded in the setup cycle so it stands through the access cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CFG: s_nxt.prdata = {19'h0_0000, s_r.cfg};
        ADDR_BAUD: s_nxt.prdata = {16'h0000, s_r.baud};
        ADDR_RXDATA: s_nxt.prdata = {23'h00_0000, s_r.rx_hold_v, s_r.rx_hold};
        ADDR_STATUS: s_nxt.prdata = {24'h00_0000, s_r.far_paused, s_r.xoff_sent,
                                     s_r.ferr, s_r.perr, s_r.overrun, ~room,
                                     s_r.echo_v, s_r.tx_hold_v};
        default: begin
        end
      endcase
    end
    // only what the access shows is popped or cleared, so nothing is lost
    if (rd_en) begin
      if (paddr == ADDR_RXDATA && s_r.prdata[8]) s_nxt.rx_hold_v = 1'b0;
      if (paddr == ADDR_STATUS) begin
        s_nxt.overrun = s_r.overrun & ~s_r.prdata[3];
        s_nxt.perr = s_r.perr & ~s_r.prdata[4];
        s_nxt.ferr = s_r.ferr & ~s_r.prdata[5];
      end
    end

    // ****************************************
    // receiver
    // ****************************************
    case (s_r.rx_st)
      LN_IDLE: begin
        if (!link_in.rxd) begin
          s_nxt.rx_st = LN_START;
          s_nxt.rx_cnt = half_baud;
        end
      end
      LN_START: begin
        if (s_r.rx_cnt != 16'h0000) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else if (link_in.rxd) begin
          s_nxt.rx_st = LN_IDLE;
        end else begin
          s_nxt.rx_st = LN_DATA;
          s_nxt.rx_cnt = s_r.baud;
          s_nxt.rx_bit = word8 ? 3'h7 : 3'h6;
          s_nxt.rx_perr = 1'b0;
        end
      end
      LN_DATA: begin
        if (s_r.rx_cnt != 16'h0000) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else begin
          s_nxt.rx_sh = {link_in.rxd, s_r.rx_sh[7:1]};
          s_nxt.rx_cnt = s_r.baud;
          s_nxt.rx_bit = s_r.rx_bit - 3'h1;
          if (s_r.rx_bit == 3'h0) begin
            s_nxt.rx_st = (par_mode == PAR_NONE) ? LN_STOP : LN_PAR;
          end
        end
      end
      LN_PAR: begin
        if (s_r.rx_cnt != 16'h0000) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else begin
          s_nxt.rx_cnt = s_r.baud;
          s_nxt.rx_st = LN_STOP;
          case (par_mode)
            PAR_EVEN: s_nxt.rx_perr = ^{link_in.rxd, rx_char};
            PAR_ODD: s_nxt.rx_perr = ~^{link_in.rxd, rx_char};
            PAR_ZERO: s_nxt.rx_perr = link_in.rxd;
            PAR_ONE: s_nxt.rx_perr = ~link_in.rxd;
            default: s_nxt.rx_perr = 1'b0;
          endcase
        end
      end
      LN_STOP: begin
        // only the first stop bit is checked, so a far end sending one
        // stop bit is still accepted when two are configured
        if (s_r.rx_cnt != 16'h0000) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else begin
          s_nxt.rx_st = LN_IDLE;
          rx_done = 1'b1;
          if (!link_in.rxd) s_nxt.ferr = 1'b1;
          if (s_r.rx_perr) s_nxt.perr = 1'b1;
        end
      end
      default: s_nxt.rx_st = LN_IDLE;
    endcase

    if (rx_done) begin
      if (s_r.cfg[CFG_TXPACE] && rx_char == CHAR_XOFF) begin
        s_nxt.far_paused = 1'b1;
      end else if (s_r.cfg[CFG_TXPACE] && rx_char == CHAR_XON) begin
        s_nxt.far_paused = 1'b0;
      end else begin
        if (!room) begin
          s_nxt.overrun = 1'b1;
        end else begin
          s_nxt.rx_hold = rx_char;
          s_nxt.rx_hold_v = 1'b1;
        end
        if (s_r.cfg[CFG_ECHO]) begin
          s_nxt.echo_hold = rx_char;
          s_nxt.echo_v = 1'b1;
        end
      end
    end
    if (!s_r.cfg[CFG_TXPACE]) s_nxt.far_paused = 1'b0;

    // ****************************************
    // receive pacing requests
    // ****************************************
    if (s_r.cfg[CFG_RXPACE]) begin
      if (!room && !s_r.xoff_sent) begin
        s_nxt.send_xoff = 1'b1;
        s_nxt.xoff_sent = 1'b1;
      end else if (room && s_r.xoff_sent && !s_r.send_xoff) begin
        s_nxt.send_xon = 1'b1;
        s_nxt.xoff_sent = 1'b0;
      end
    end else begin
      s_nxt.xoff_sent = 1'b0;
    end

    // ****************************************
    // transmitter
    // ****************************************
    case (s_r.tx_st)
      LN_IDLE: begin
        s_nxt.lo.txd = 1'b1;
        s_nxt.tx_cnt = s_r.baud;
        s_nxt.tx_stop2 = s_r.cfg[CFG_STOP2];
        s_nxt.tx_bit = word8 ? 3'h7 : 3'h6;
        // control characters bypass both pauses so pacing never deadlocks
        if (s_r.send_xoff || s_r.send_xon) begin
          s_nxt.tx_sh = s_r.send_xoff ? CHAR_XOFF : CHAR_XON;
          s_nxt.send_xoff = 1'b0;
          s_nxt.send_xon = s_r.send_xoff ? s_r.send_xon : 1'b0;
          s_nxt.tx_st = LN_START;
        end else if (!hw_hold && !s_r.far_paused) begin
          if (s_r.echo_v) begin
            s_nxt.tx_sh = s_r.echo_hold;
            s_nxt.echo_v = 1'b0;
            s_nxt.tx_st = LN_START;
          end else if (s_r.tx_hold_v) begin
            s_nxt.tx_sh = s_r.tx_hold;
            s_nxt.tx_hold_v = 1'b0;
            s_nxt.tx_st = LN_START;
          end
        end
        if (s_nxt.tx_st == LN_START) begin
          s_nxt.lo.txd = 1'b0;
          s_nxt.tx_par = word8 ? ^s_nxt.tx_sh : ^s_nxt.tx_sh[6:0];
        end
      end
      LN_START, LN_DATA, LN_PAR, LN_STOP: begin
        if (s_r.tx_cnt != 16'h0000) begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end else begin
          s_nxt.tx_cnt = s_r.baud;
          case (s_r.tx_st)
            LN_START, LN_DATA: begin
              if (s_r.tx_st == LN_DATA && s_r.tx_bit == 3'h0) begin
                if (par_mode == PAR_NONE) begin
                  s_nxt.tx_st = LN_STOP;
                  s_nxt.lo.txd = 1'b1;
                end else begin
                  s_nxt.tx_st = LN_PAR;
                  case (par_mode)
                    PAR_EVEN: s_nxt.lo.txd = s_r.tx_par;
                    PAR_ODD: s_nxt.lo.txd = ~s_r.tx_par;
                    PAR_ONE: s_nxt.lo.txd = 1'b1;
                    default: s_nxt.lo.txd = 1'b0;
                  endcase
                end
              end else begin
                if (s_r.tx_st == LN_DATA) s_nxt.tx_bit = s_r.tx_bit - 3'h1;
                s_nxt.tx_st = LN_DATA;
                s_nxt.lo.txd = s_r.tx_sh[0];
                s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
              end
            end
            LN_PAR: begin
              s_nxt.tx_st = LN_STOP;
              s_nxt.lo.txd = 1'b1;
            end
            default: begin
              if (s_r.tx_stop2) begin
                s_nxt.tx_stop2 = 1'b0;
              end else begin
                s_nxt.tx_st = LN_IDLE;
              end
            end
          endcase
        end
      end
      default: s_nxt.tx_st = LN_IDLE;
    endcase

    // ****************************************
    // modem control outputs, terminal side
    // ****************************************
    case (rts_mode)
      HS_ON: s_nxt.lo.rts = 1'b1;
      HS_ROOM: s_nxt.lo.rts = room;
      default: s_nxt.lo.rts = 1'b0;
    endcase
    case (dtr_mode)
      HS_ON: s_nxt.lo.dtr = 1'b1;
      HS_ROOM: s_nxt.lo.dtr = room;
      default: s_nxt.lo.dtr = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.cfg <= CFG_RESET;
      s_r.baud <= BAUD_RESET;
      s_r.lo.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : serial_remote_port

// ### test/host_model.sv
// partner: remote host on the far end of the serial link
`timescale 1ns/1ns
module host_model
  import serial_port_pkg::*;
#(
  parameter int BIT_CLKS = 4
)(
  input wire logic pclk,
  input wire link_out_t lo,
  output link_in_t li
);
  int nb = 8;
  logic [9:0] got[$];
  initial li = 3'b111;
  // v holds data then parity, lsb first; stop is the return to mark
  task automatic send(input logic [9:0] v, input int n, input bit obey);
    while (obey && !lo.rts) @(posedge pclk);
    li.rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      li.rxd <= v[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    li.rxd <= 1'b1;
    repeat (3 * BIT_CLKS) @(posedge pclk);
  endtask : send
  always begin : capture
    logic [9:0] w;
    @(negedge lo.txd);
    w = 10'h000;
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge pclk);
      w[i] = lo.txd;
    end
    repeat (BIT_CLKS) @(posedge pclk);
    // a missing stop bit spoils the whole word
    if (lo.txd !== 1'b1) w = 10'h3ff;
    got.push_back(w);
  end
endmodule : host_model

// ### test/serial_remote_port_asserts.sv
// checker: port assertions of the serial remote port
`timescale 1ns/1ns
module serial_remote_port_asserts
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire link_in_t link_in,
  input wire link_out_t link_out
);
  // modes are trusted only a cycle after a cfg write settles
  logic [12:0] cfg_r;
  logic [12:0] old_r;
  logic [15:0] baud_r;
  logic [2:0] cts_lo_r;
  logic [2:0] dsr_lo_r;
  logic [5:0] hi_r;
  wire logic ok = cfg_r == old_r;
  wire logic wr = psel && penable && pwrite;
  wire logic hit = paddr inside {ADDR_CFG, ADDR_BAUD, ADDR_TXDATA, ADDR_RXDATA, ADDR_STATUS};
  // a fall after 48 high cycles can only be a start bit at 4 clocks a bit
  wire logic idle = hi_r >= 6'h30;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
      old_r <= CFG_RESET;
      baud_r <= BAUD_RESET;
      cts_lo_r <= 3'h0;
      dsr_lo_r <= 3'h0;
      hi_r <= 6'h0;
    end else begin
      old_r <= cfg_r;
      if (wr && paddr == ADDR_CFG) cfg_r <= pwdata[12:0];
      if (wr && paddr == ADDR_BAUD) baud_r <= pwdata[15:0];
      cts_lo_r <= link_in.cts ? 3'h0 : (cts_lo_r == 3'h4 ? 3'h4 : cts_lo_r + 3'h1);
      dsr_lo_r <= link_in.dsr ? 3'h0 : (dsr_lo_r == 3'h4 ? 3'h4 : dsr_lo_r + 3'h1);
      hi_r <= !link_out.txd ? 6'h0 : (hi_r == 6'h3f ? hi_r : hi_r + 6'h1);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_rts_off_low: assert property (ok && cfg_r[9:8] == HS_OFF |-> !link_out.rts)
    else $error("rts high in off mode");
  a_rts_on_high: assert property (ok && cfg_r[9:8] == HS_ON |-> link_out.rts)
    else $error("rts low in on mode");
  a_dtr_off_low: assert property (
    ok && (cfg_r[11:10] == HS_OFF || cfg_r[CFG_BALANCED]) |-> !link_out.dtr)
    else $error("dtr high while off or balanced");
  a_dtr_on_high: assert property (
    ok && cfg_r[11:10] == HS_ON && !cfg_r[CFG_BALANCED] |-> link_out.dtr)
    else $error("dtr low in on mode");
  a_start_bit_len: assert property (
    baud_r == 16'h0003 && $fell(link_out.txd) |-> !link_out.txd [*4])
    else $error("start bit not four clocks");
  a_cts_holds_tx: assert property (
    ok && cfg_r[9:8] == HS_ROOM && !cfg_r[CFG_RXPACE] && cts_lo_r == 3'h4 && idle
    |-> !$fell(link_out.txd))
    else $error("frame started while cts low");
  a_dsr_holds_tx: assert property (
    ok && cfg_r[11:10] == HS_ROOM && !cfg_r[CFG_BALANCED] && !cfg_r[CFG_RXPACE]
    && dsr_lo_r == 3'h4 && idle |-> !$fell(link_out.txd))
    else $error("frame started while dsr low");
  a_addr_error: assert property (psel && penable |-> pready && pslverr == !hit)
    else $error("slave error does not match address map");
endmodule : serial_remote_port_asserts
bind serial_remote_port serial_remote_port_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
  .link_out(link_out));

// ### test/tb_serial_remote_port.sv
// testbench: scenarios for the serial remote port
`timescale 1ns/1ns
module tb_serial_remote_port;
  import serial_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd_v;
  logic pready;
  logic pslverr;
  logic err_v;
  link_in_t link_in;
  link_out_t link_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  serial_remote_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_in(link_in), .link_out(link_out));
  host_model #(.BIT_CLKS(4)) u_host (.pclk(pclk), .lo(link_out), .li(link_in));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // ****************************************
  // bus, compare and closing tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    // read data and error stand in the access cycle
    err_v = pslverr;
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_q(input int n);
    for (int k = 0; k < 3000 && u_host.got.size() < n; k++) @(posedge pclk);
    chk(32'(u_host.got.size()), 32'(n));
  endtask : wait_q
  function automatic logic pbit(input logic [2:0] p, input logic [7:0] d);
    case (p)
      PAR_EVEN: return ^d;
      PAR_ODD: return ~^d;
      PAR_ONE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : pbit
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic t_reset();
    chk(32'(link_out), 32'h4);
    apb(1'b0, ADDR_BAUD, 32'h0);
    chk(rd_v, 32'(BAUD_RESET));
    apb(1'b0, 12'h014, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b1, ADDR_BAUD, 32'h0000_0003);
  endtask : t_reset
  task automatic t_lines();
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, ADDR_CFG, 32'h1 | (32'(m[0]) << 8) | (32'(m[1]) << 10) | (32'(m[2]) << 12));
      repeat (3) @(posedge pclk);
      chk({link_out.rts, link_out.dtr}, 32'({m[0], m[1] & ~m[2]}));
    end
  endtask : t_lines
  task automatic t_tx_fmt();
    logic [7:0] d;
    for (int p = 0; p < 5; p++) begin
      d = p[0] ? 8'ha5 : 8'h25;
      apb(1'b1, ADDR_CFG, 32'(p[0]) | (32'(p[1]) << 1) | (32'(p) << 2));
      u_host.nb = 7 + p[0] + (p != 0);
      u_host.got.delete();
      apb(1'b1, ADDR_TXDATA, 32'ha5);
      wait_q(1);
      chk(32'(u_host.got[0]), 32'(d) | (32'(pbit(3'(p), d)) << (7 + p[0])));
    end
    u_host.nb = 8;
  endtask : t_tx_fmt
  task automatic t_echo();
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, ADDR_CFG, 32'h1 | (32'(e) << 5));
      u_host.got.delete();
      u_host.send(10'h3c, 8, 1'b0);
      repeat (60) @(posedge pclk);
      chk(32'(u_host.got.size()), 32'(e));
      if (e == 1) chk(32'(u_host.got[0]), 32'h3c);
      apb(1'b0, ADDR_RXDATA, 32'h0);
      chk(rd_v, 32'h13c);
    end
  endtask : t_echo
  task automatic t_room();
    apb(1'b1, ADDR_CFG, 32'ha01);
    repeat (60) @(posedge pclk);
    chk({link_out.rts, link_out.dtr}, 32'h3);
    u_host.send(10'h41, 8, 1'b1);
    chk({link_out.rts, link_out.dtr}, 32'h0);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rd_v, 32'h141);
    for (int k = 0; k < 2; k++) begin
      u_host.got.delete();
      u_host.li <= k ? 3'b110 : 3'b101;
      repeat (8) @(posedge pclk);
      chk({link_out.rts, link_out.dtr}, 32'h3);
      apb(1'b1, ADDR_TXDATA, 32'h77);
      repeat (100) @(posedge pclk);
      chk(32'(u_host.got.size()), 32'h0);
      u_host.li <= 3'b111;
      wait_q(1);
      chk(32'(u_host.got[0]), 32'h77);
      repeat (60) @(posedge pclk);
    end
  endtask : t_room
  task automatic t_pace();
    apb(1'b1, ADDR_CFG, 32'h41);
    u_host.got.delete();
    u_host.send(10'(CHAR_XOFF), 8, 1'b0);
    apb(1'b1, ADDR_TXDATA, 32'h55);
    repeat (100) @(posedge pclk);
    chk(32'(u_host.got.size()), 32'h0);
    u_host.send(10'(CHAR_XON), 8, 1'b0);
    wait_q(1);
    chk(32'(u_host.got[0]), 32'h55);
    apb(1'b1, ADDR_CFG, 32'h81);
    u_host.got.delete();
    u_host.send(10'h20, 8, 1'b0);
    wait_q(1);
    chk(32'(u_host.got[0]), 32'(CHAR_XOFF));
    apb(1'b0, ADDR_RXDATA, 32'h0);
    wait_q(2);
    chk(32'(u_host.got[1]), 32'(CHAR_XON));
  endtask : t_pace
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lines();
    t_tx_fmt();
    t_echo();
    t_room();
    t_pace();
    complete_run();
  end
  // the scenarios need under two thousand cycles; twenty times that means a hang
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_serial_remote_port
